// ### verilog/rtcd_regs.svh
// Purpose: register offsets, bit positions, reset values and timing figures
// Assumes: 8-bit registers behind a 4-bit register address
// Notes: definitions only
`ifndef RTCD_REGS_SVH
`define RTCD_REGS_SVH
// register offsets
`define RTCD_A_TRIM 4'h7
`define RTCD_A_WMIN 4'h8
`define RTCD_A_WHOUR 4'h9
`define RTCD_A_WDAY 4'hA
`define RTCD_A_CTRL 4'hE
`define RTCD_A_STAT 4'hF
// status bit positions
`define RTCD_ST_B7 7
`define RTCD_ST_BAT 6
`define RTCD_ST_OSC 5
`define RTCD_ST_PON 4
`define RTCD_ST_EVT 3
`define RTCD_ST_TMR 2
`define RTCD_ST_WK 1
`define RTCD_ST_MO 0
// control bit positions
`define RTCD_CT_WKEN 7
`define RTCD_CT_RO 5
// reset values and masks
`define RTCD_ST_INIT 8'h70
`define RTCD_ZERO8 8'h00
`define RTCD_ST_CLRONLY 8'h5F
`define RTCD_ST_PONHOLD 8'h70
`define RTCD_DAY_MASK 8'h7F
`define RTCD_HR_MASK 8'h3F
`define RTCD_PM_BIT 5
`define RTCD_BCD12 5'h12
// timing figures
`define RTCD_CLK_KHZ 10000
`define RTCD_SAMPLE_MS 7.8
`define RTCD_PERIOD_MS 1000
`endif

// ### verilog/rtcd_pkg.sv
// Purpose: types shared by the detect and status block
// Assumes: nothing beyond the register header
// Notes: types only
package rtcd_pkg;
    // register port request, one write per cycle
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtcd_req_t;
    // analogue supervisor levels
    typedef struct packed {
        logic por;
        logic osc_stop;
        logic bat_low;
    } rtcd_det_t;
    // flag set pulses from neighbouring logic
    typedef struct packed {
        logic evt;
        logic tmr;
        logic mo;
    } rtcd_evt_t;
    // weekday alarm settings for the comparator
    typedef struct packed {
        logic enable;
        logic [6:0] days;
        logic [7:0] hour24;
        logic [7:0] minute;
    } rtcd_alarm_t;
endpackage

// ### verilog/rtcd_top.sv
// Purpose: power-on, oscillator-stop and battery-drop flags with register file
// Assumes: register port and event inputs synchronous to clk
// Notes: supervisor levels pass a two-stage synchroniser first
`timescale 1ns/1ps
`include "rtcd_regs.svh"

// What this block does
// - detector results live in status register Fh
// - power-on reset sets the power-on flag
// - power-on flag held until zero written
// - power-on flag clears registers, releases interrupts
// - init: trim, control zero; status 70h
// - read-only control bit reads zero, ignores writes
// - oscillator stop drives its flag to zero
// - oscillator flag kept until one written
// - battery drop sets the battery flag
// - battery flag held until zero written
// - battery sampled 7.8 ms each second
// - sampling stops while battery flag set
// - day mask bit6 Saturday, bit0 Sunday
// - 12-hour alarm hours: 12h midnight, 32h noon
// - no weekday alarm with empty day mask
module rtcd_top #(
    parameter int CNT_W = 24,
    parameter int WIN_CYC = int'(`RTCD_SAMPLE_MS * `RTCD_CLK_KHZ),
    parameter int PERIOD_CYC = `RTCD_PERIOD_MS * `RTCD_CLK_KHZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire rtcd_pkg::rtcd_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire rtcd_pkg::rtcd_det_t det_in,
    input wire rtcd_pkg::rtcd_evt_t evt_set,
    input wire logic wk_match,
    input wire logic mode_24h,
    output logic bat_sample_en,
    output logic int_wk_oe,
    output logic int_ev_oe,
    output rtcd_pkg::rtcd_alarm_t alarm_cfg
);
    import rtcd_pkg::*;

    // synchroniser stages; stage one feeds stage two only
    rtcd_det_t sync1_q;
    rtcd_det_t sync2_q;
    // register file
    logic [7:0] trim_q, trim_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] wmin_q, wmin_d;
    logic [7:0] whour_q, whour_d;
    logic [7:0] wday_q, wday_d;
    logic [7:0] st_q, st_d;
    // sampling timebase
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic samp_q, samp_d;
    // output registers
    logic [7:0] rdata_q, rdata_d;
    logic intwk_q, intwk_d;
    logic intev_q, intev_d;
    rtcd_alarm_t alarm_q, alarm_d;
    // decoded write strobes
    logic wr_stat;

    assign wr_stat = reg_req.wr && (reg_req.addr == `RTCD_A_STAT);

    // 12-hour alarm hour to 24-hour BCD
    function automatic logic [7:0] to_24h(input logic [7:0] h, input logic m24);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = h[3:0];
        hi = {3'h0, h[4]};
        if (m24) begin
            return h & `RTCD_HR_MASK;
        end
        // twelve o'clock is hour zero of its half day
        if (h[4:0] == `RTCD_BCD12) begin
            lo = 4'h0;
            hi = 4'h0;
        end
        // afternoon adds twelve in BCD
        if (h[`RTCD_PM_BIT]) begin
            lo = lo + 4'h2;
            hi = hi + 4'h1;
            if (lo > 4'h9) begin
                lo = lo - 4'hA;
                hi = hi + 4'h1;
            end
        end
        return {hi, lo};
    endfunction

    // supervisor levels: two flops, no logic between
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= det_in;
            sync2_q <= sync1_q;
        end
    end

    // register file next state: holds, then write, then hardware sets, then power-on
    always_comb begin
        trim_d = trim_q;
        ctrl_d = ctrl_q;
        wmin_d = wmin_q;
        whour_d = whour_q;
        wday_d = wday_q;
        st_d = st_q;
        // software writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                `RTCD_A_TRIM: trim_d = reg_req.wdata;
                `RTCD_A_WMIN: wmin_d = reg_req.wdata;
                `RTCD_A_WHOUR: whour_d = reg_req.wdata & `RTCD_HR_MASK;
                `RTCD_A_WDAY: wday_d = reg_req.wdata & `RTCD_DAY_MASK;
                `RTCD_A_CTRL: begin
                    ctrl_d = reg_req.wdata;
                    ctrl_d[`RTCD_CT_RO] = 1'b0;
                end
                `RTCD_A_STAT: begin
                    // clear-only flags: zero clears, one keeps
                    st_d = st_q & (reg_req.wdata | ~`RTCD_ST_CLRONLY);
                    st_d[`RTCD_ST_B7] = reg_req.wdata[`RTCD_ST_B7];
                    // oscillator flag: one rearms, zero ignored
                    if (reg_req.wdata[`RTCD_ST_OSC]) begin
                        st_d[`RTCD_ST_OSC] = 1'b1;
                    end
                end
                default: begin
                    // unmapped or not held here: ignored
                end
            endcase
        end
        // hardware sets come after the write so they win
        if (evt_set.evt) begin
            st_d[`RTCD_ST_EVT] = 1'b1;
        end
        if (evt_set.tmr) begin
            st_d[`RTCD_ST_TMR] = 1'b1;
        end
        if (evt_set.mo) begin
            st_d[`RTCD_ST_MO] = 1'b1;
        end
        // weekday alarm needs enable and at least one day
        if (wk_match && ctrl_q[`RTCD_CT_WKEN] && (|wday_q[6:0])) begin
            st_d[`RTCD_ST_WK] = 1'b1;
        end
        // battery drop counts only inside a sampling window
        if (sync2_q.bat_low && samp_q) begin
            st_d[`RTCD_ST_BAT] = 1'b1;
        end
        // oscillator stop overrides any earlier write of one
        if (sync2_q.osc_stop) begin
            st_d[`RTCD_ST_OSC] = 1'b0;
        end
        // while power-on flag stands, all else reads zero except the battery and oscillator flags
        if (st_q[`RTCD_ST_PON]) begin
            trim_d = `RTCD_ZERO8;
            ctrl_d = `RTCD_ZERO8;
            wmin_d = `RTCD_ZERO8;
            whour_d = `RTCD_ZERO8;
            wday_d = `RTCD_ZERO8;
            // battery flag kept so it still reads one after init
            st_d = st_d & `RTCD_ST_PONHOLD;
        end
        // power-on reset loads init values in the same cycle
        if (sync2_q.por) begin
            trim_d = `RTCD_ZERO8;
            ctrl_d = `RTCD_ZERO8;
            wmin_d = `RTCD_ZERO8;
            whour_d = `RTCD_ZERO8;
            wday_d = `RTCD_ZERO8;
            st_d = `RTCD_ST_INIT;
        end
    end

    // register file flops; digital reset gives init values too
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trim_q <= `RTCD_ZERO8;
            ctrl_q <= `RTCD_ZERO8;
            wmin_q <= `RTCD_ZERO8;
            whour_q <= `RTCD_ZERO8;
            wday_q <= `RTCD_ZERO8;
            st_q <= `RTCD_ST_INIT;
        end else begin
            trim_q <= trim_d;
            ctrl_q <= ctrl_d;
            wmin_q <= wmin_d;
            whour_q <= whour_d;
            wday_q <= wday_d;
            st_q <= st_d;
        end
    end

    // one-second timebase and sampling window
    // trade-off: window aligned to counter start, not to a second edge
    always_comb begin
        if (cnt_q == CNT_W'(PERIOD_CYC - 1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
        // window closed while battery flag is set
        samp_d = (cnt_d < CNT_W'(WIN_CYC)) && !st_d[`RTCD_ST_BAT];
    end

    // timebase flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            samp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            samp_q <= samp_d;
        end
    end

    // read mux, interrupt enables and alarm settings
    always_comb begin
        case (reg_req.addr)
            `RTCD_A_TRIM: rdata_d = trim_q;
            `RTCD_A_WMIN: rdata_d = wmin_q;
            `RTCD_A_WHOUR: rdata_d = whour_q;
            `RTCD_A_WDAY: rdata_d = wday_q;
            `RTCD_A_CTRL: rdata_d = ctrl_q;
            `RTCD_A_STAT: rdata_d = st_q;
            default: rdata_d = `RTCD_ZERO8;
        endcase
        // open-drain pins released while power-on flag stands
        intwk_d = st_d[`RTCD_ST_WK] && !st_d[`RTCD_ST_PON];
        intev_d = (st_d[`RTCD_ST_EVT] || st_d[`RTCD_ST_TMR] || st_d[`RTCD_ST_MO])
            && !st_d[`RTCD_ST_PON];
        alarm_d.enable = ctrl_d[`RTCD_CT_WKEN];
        alarm_d.days = wday_d[6:0];
        alarm_d.hour24 = to_24h(whour_d, mode_24h);
        alarm_d.minute = wmin_d;
    end

    // output flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `RTCD_ZERO8;
            intwk_q <= 1'b0;
            intev_q <= 1'b0;
            alarm_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            intwk_q <= intwk_d;
            intev_q <= intev_d;
            alarm_q <= alarm_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign int_wk_oe = intwk_q;
    assign int_ev_oe = intev_q;
    assign bat_sample_en = samp_q;
    assign alarm_cfg = alarm_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_bat_clear;
        wr_stat && !reg_req.wdata[`RTCD_ST_BAT] && !sync2_q.por;
    endsequence

    AST_POR_INIT: assert property (sync2_q.por |=>
        st_q == `RTCD_ST_INIT && trim_q == `RTCD_ZERO8 && ctrl_q == `RTCD_ZERO8)
        else $error("power-on did not load init values");
    AST_PON_HOLD: assert property (st_q[`RTCD_ST_PON] &&
        !(wr_stat && !reg_req.wdata[`RTCD_ST_PON]) |=> st_q[`RTCD_ST_PON])
        else $error("power-on flag dropped without a zero write");
    AST_PON_W1: assert property (!st_q[`RTCD_ST_PON] && !sync2_q.por &&
        wr_stat |=> !st_q[`RTCD_ST_PON])
        else $error("power-on flag set by a write");
    AST_PON_CLR: assert property (st_q[`RTCD_ST_PON] |->
        trim_q == `RTCD_ZERO8 && wday_q == `RTCD_ZERO8 && !int_wk_oe && !int_ev_oe)
        else $error("registers or interrupts active under power-on flag");
    AST_RO_BIT: assert property (reg_req.wr && reg_req.addr == `RTCD_A_CTRL
        |=> !ctrl_q[`RTCD_CT_RO])
        else $error("read-only control bit took a write");
    AST_OSC_STOP: assert property (sync2_q.osc_stop && !sync2_q.por
        |=> !st_q[`RTCD_ST_OSC])
        else $error("oscillator stop did not clear its flag");
    // a zero write in the cycle after the set is a legal clear, so it is left out
    AST_BAT_SET: assert property ((sync2_q.bat_low && samp_q && !sync2_q.por) ##1
        !(wr_stat && !reg_req.wdata[`RTCD_ST_BAT]) |-> st_q[`RTCD_ST_BAT] [*2])
        else $error("battery drop not flagged");
    AST_BAT_CLR: assert property (st_q[`RTCD_ST_BAT] && !st_q[`RTCD_ST_PON]
        ##0 s_bat_clear |=> !st_q[`RTCD_ST_BAT])
        else $error("battery flag not cleared by zero write");
    AST_BAT_STOP: assert property (st_q[`RTCD_ST_BAT] |-> !bat_sample_en)
        else $error("sampling while battery flag set");
    AST_WINDOW: assert property (bat_sample_en |-> cnt_q < CNT_W'(WIN_CYC))
        else $error("sampling outside window");
    AST_WK_EMPTY: assert property (wday_q == `RTCD_ZERO8 &&
        !st_q[`RTCD_ST_WK] && !evt_set.evt |=> !st_q[`RTCD_ST_WK])
        else $error("weekday alarm with empty day mask");
    AST_NOON: assert property (!mode_24h && reg_req.wr &&
        reg_req.addr == `RTCD_A_WHOUR && reg_req.wdata == 8'h32 &&
        !st_q[`RTCD_ST_PON] && !sync2_q.por |=> alarm_cfg.hour24 == 8'h12)
        else $error("12-hour noon not converted");
endmodule

// ### verification/rtcd_host.sv
// Purpose: host model driving the register port of the status block
// Assumes: one write strobe per call, read data settles a cycle after the address
// Notes: write data is inverted once the strobe drops, so stale data never helps
`timescale 1ns/1ps
module rtcd_host (
    input wire logic clk,
    output rtcd_pkg::rtcd_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import rtcd_pkg::*;
    // idle bus until the first call
    initial reg_req = '0;
    // single-cycle strobe; zero clears sticky flags, one rearms the oscillator flag
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, a, ~d};
    endtask
    // address held while read data follows it one cycle later
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
endmodule

// ### verification/rtcd_top_tb_top.sv
// Purpose: self-checking bench for the detect and status flags
// Assumes: sampling period shortened to 200 cycles with a 20-cycle window
// Notes: rows cover plain register traffic, hand tests cover the detectors
`timescale 1ns/1ps
`include "rtcd_regs.svh"
module rtcd_top_tb_top;
    import rtcd_pkg::*;
    localparam int PER = 200;
    localparam int WIN = 20;
    localparam logic [3:0] ST = `RTCD_A_STAT;
    // row: address, data written, value read back
    typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] q;} rtcd_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    rtcd_req_t reg_req;
    logic [7:0] reg_rdata;
    rtcd_det_t det_in = '0;
    rtcd_evt_t evt_set = '0;
    logic wk_match = 1'b0;
    logic mode_24h = 1'b0;
    logic bat_sample_en;
    logic int_wk_oe;
    logic int_ev_oe;
    rtcd_alarm_t alarm_cfg;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int k;
    logic [7:0] v;
    // unmapped address 3 must read zero; status bit 7 is plain read-write
    rtcd_row_t rows [8] = '{'{4'h7, 8'h55, 8'h55}, '{4'hE, 8'hFF, 8'hDF}, '{4'hA, 8'h41, 8'h41},
        '{4'h8, 8'h30, 8'h30}, '{4'h9, 8'h32, 8'h32}, '{4'h3, 8'hAA, 8'h00},
        '{4'hF, 8'hA0, 8'hA0}, '{4'hF, 8'h20, 8'h20}};
    // 12-hour codes and the 24-hour hours they stand for
    logic [7:0] hrs [4] = '{8'h12, 8'h32, 8'h21, 8'h31};
    logic [7:0] hre [4] = '{8'h00, 8'h12, 8'h13, 8'h23};

    rtcd_top #(.PERIOD_CYC(PER), .WIN_CYC(WIN)) dut_u (.clk(clk), .rstn(rstn),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .det_in(det_in), .evt_set(evt_set),
        .wk_match(wk_match), .mode_24h(mode_24h), .bat_sample_en(bat_sample_en),
        .int_wk_oe(int_wk_oe), .int_ev_oe(int_ev_oe), .alarm_cfg(alarm_cfg));
    rtcd_host host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    // hang guard, well above the roughly 900 cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
        host_u.rd(a, v);
        chk(nm, e, v);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one set pulse on the event flag
    task automatic pulse_evt;
        @(posedge clk);
        evt_set <= 3'b100;
        @(posedge clk);
        evt_set <= '0;
    endtask
    // count sampling-window cycles over n clocks
    task automatic cnt(input int n);
        k = 0;
        repeat (n) begin
            @(negedge clk);
            k += int'(bat_sample_en === 1'b1);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        cy(8);
        rstn <= 1'b1;
        rc("trim init", `RTCD_A_TRIM, 8'h00);
        rc("ctrl init", `RTCD_A_CTRL, 8'h00);
        rc("stat init", ST, `RTCD_ST_INIT);
        host_u.wr(`RTCD_A_TRIM, 8'h55);
        rc("trim held", `RTCD_A_TRIM, 8'h00);
        host_u.wr(ST, 8'h00);
        rc("stat clear", ST, 8'h20);
        host_u.wr(ST, 8'h50);
        rc("stat one", ST, 8'h20);
        $display("test init done");
        foreach (rows[i]) begin
            host_u.wr(rows[i].a, rows[i].d);
            rc("row", rows[i].a, rows[i].q);
        end
        chk("days", 8'h41, {1'b0, alarm_cfg.days});
        chk("minute", 8'h30, alarm_cfg.minute);
        chk("enable", 8'h01, alarm_cfg.enable);
        foreach (hrs[i]) begin
            host_u.wr(`RTCD_A_WHOUR, hrs[i]);
            cy(2);
            chk("hour12", hre[i], alarm_cfg.hour24);
        end
        mode_24h <= 1'b1;
        host_u.wr(`RTCD_A_WHOUR, 8'h23);
        cy(2);
        chk("hour24", 8'h23, alarm_cfg.hour24);
        $display("test registers done");
        @(posedge clk);
        wk_match <= 1'b1;
        evt_set <= '1;
        @(posedge clk);
        wk_match <= 1'b0;
        evt_set <= '0;
        rc("flags set", ST, 8'h2F);
        chk("wk oe", 8'h01, int_wk_oe);
        chk("ev oe", 8'h01, int_ev_oe);
        // a set pulse in the same cycle as the clearing write must win
        fork
            host_u.wr(ST, 8'h20);
            pulse_evt();
        join
        rc("set beats clear", ST, 8'h28);
        chk("wk oe off", 8'h00, int_wk_oe);
        host_u.wr(`RTCD_A_WDAY, 8'h00);
        host_u.wr(ST, 8'h20);
        @(posedge clk);
        wk_match <= 1'b1;
        @(posedge clk);
        wk_match <= 1'b0;
        rc("empty mask", ST, 8'h20);
        $display("test flags done");
        @(posedge clk);
        det_in.osc_stop <= 1'b1;
        cy(4);
        det_in.osc_stop <= 1'b0;
        rc("osc stop", ST, 8'h00);
        host_u.wr(ST, 8'h20);
        rc("osc rearm", ST, 8'h20);
        // wait for a window to open, so the drop lands well inside it
        while (bat_sample_en === 1'b1) begin
            @(negedge clk);
        end
        while (bat_sample_en !== 1'b1) begin
            @(negedge clk);
        end
        @(posedge clk);
        det_in.bat_low <= 1'b1;
        cy(4);
        chk("sample off", 8'h00, bat_sample_en);
        rc("bat flag", ST, 8'h60);
        cnt(PER);
        chk("no sampling", 8'h00, k[7:0]);
        @(posedge clk);
        det_in.bat_low <= 1'b0;
        cy(3);
        host_u.wr(ST, 8'h20);
        cnt(2 * PER);
        chk("window", 8'(2 * WIN), k[7:0]);
        $display("test detectors done");
        pulse_evt();
        @(posedge clk);
        det_in.por <= 1'b1;
        cy(4);
        det_in.por <= 1'b0;
        cy(4);
        chk("oe released", 8'h00, {int_wk_oe, int_ev_oe});
        rc("por trim", `RTCD_A_TRIM, 8'h00);
        rc("por ctrl", `RTCD_A_CTRL, 8'h00);
        rc("por stat", ST, `RTCD_ST_INIT);
        $display("test power-on done");
        stop_test();
    end
endmodule
